// ---- logic/bsp_pkg.sv ----
// Shared constants and types for the boundary-scan test port
package bsp_pkg;
   localparam int PIN_N = 5;
   localparam int PIN_TCK = 0;
   localparam int PIN_TMS = 1;
   localparam int PIN_TDI = 2;
   localparam int PIN_TRST = 3;
   localparam int PIN_IOEN = 4;
   // Idle levels: test clock low, pulled-up lines high, so no false edge
   localparam logic [PIN_N-1:0] PIN_RST_VAL = 5'h1e;
   localparam int IR_W = 4;
   localparam int ID_W = 32;
   localparam logic [IR_W-1:0] INS_IDCODE = 4'h1;
   localparam logic [IR_W-1:0] INS_BYPASS = 4'hf;
   localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
   // Identification value is arbitrary; bit 0 set as scan convention asks
   localparam logic [ID_W-1:0] ID_VALUE = 32'h0a5c_3001;
   typedef enum logic [3:0] {
      BSP_RESET, BSP_IDLE, BSP_SEL_DR, BSP_CAP_DR, BSP_SH_DR, BSP_EX1_DR,
      BSP_PAU_DR, BSP_EX2_DR, BSP_UPD_DR, BSP_SEL_IR, BSP_CAP_IR, BSP_SH_IR,
      BSP_EX1_IR, BSP_PAU_IR, BSP_EX2_IR, BSP_UPD_IR
   } bsp_state_t;
endpackage

// ---- logic/bsp_pin_if.sv ----
// Synchronised pin levels and edge pulses between sampler and port logic
`timescale 1ns/1ps
`default_nettype none
interface bsp_pin_if;
   logic [bsp_pkg::PIN_N-1:0] lvl;
   logic [bsp_pkg::PIN_N-1:0] rise;
   logic [bsp_pkg::PIN_N-1:0] fall;
   modport src (output lvl, output rise, output fall);
   modport dst (input lvl, input rise, input fall);
endinterface
`default_nettype wire

// ---- logic/bsp_pin_sync.sv ----
// Two-stage pin synchroniser with rise and fall detection per pin
`timescale 1ns/1ps
`default_nettype none
module bsp_pin_sync
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Raw pins
   input wire logic [bsp_pkg::PIN_N-1:0] pin_raw,
   // Synchronised view
   bsp_pin_if.src pins
);
   import bsp_pkg::*;

   logic [PIN_N-1:0] meta_q;
   logic [PIN_N-1:0] sync_q;
   logic [PIN_N-1:0] prev_q;

   genvar g;
   generate
      for (g = 0; g < PIN_N; g++)
      begin : g_pin
         always_ff @(posedge clk_sys or negedge rst_n)
         begin
            if (!rst_n)
            begin
               meta_q[g] <= PIN_RST_VAL[g];
               sync_q[g] <= PIN_RST_VAL[g];
               prev_q[g] <= PIN_RST_VAL[g];
            end
            else
            begin
               meta_q[g] <= pin_raw[g];
               sync_q[g] <= meta_q[g];
               prev_q[g] <= sync_q[g];
            end
         end
         // Edges seen only past the second stage
         assign pins.lvl[g] = sync_q[g];
         assign pins.rise[g] = sync_q[g] & ~prev_q[g];
         assign pins.fall[g] = ~sync_q[g] & prev_q[g];
      end
   endgenerate
endmodule
`default_nettype wire

// ---- logic/bsp_tap.sv ----
// Boundary-scan test access port with digital I/O float control
//
// What this block does
// - Pulling test_port_reset_n low resets the port controller at once.
// - A rising test_port_reset_n puts the port in identification mode.
// - While test_port_reset_n is low the device leaves test mode.
// - test_state_select is sampled on each rising test clock edge.
// - test_serial_in is captured on rising test clock edges in the shift states.
// - test_serial_out changes on falling edges, floats when not shifting.
// - Enable and port reset both low float every digital I/O pin.
// - Enable high lets the digital I/O pins work normally.
`timescale 1ns/1ps
`default_nettype none
module bsp_tap
#(
   parameter logic [bsp_pkg::ID_W-1:0] ID_CODE = bsp_pkg::ID_VALUE
)
(
   // System clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Test port pins from the tester
   input wire logic test_shift_clock,
   input wire logic test_state_select,
   input wire logic test_serial_in,
   input wire logic test_port_reset_n,
   input wire logic pin_drive_enable,
   // Serial output pin
   output logic test_serial_out,
   output logic test_serial_out_oe,
   // Device-wide controls
   output logic test_mode_active,
   output logic pins_float,
   output logic [bsp_pkg::IR_W-1:0] active_instruction
);
   import bsp_pkg::*;

   bsp_pin_if pins ();
   logic port_rst_n;
   logic tck_rise;
   logic tck_fall;
   logic tms;
   logic tdi;
   bsp_state_t state_q;
   bsp_state_t state_d;
   logic [IR_W-1:0] ir_sh_q;
   logic [IR_W-1:0] ir_q;
   logic [ID_W-1:0] dr_sh_q;
   logic tdo_q;
   logic tdo_oe_q;
   logic test_mode_q;
   logic float_q;
   logic shifting;
   logic shift_bit;
   logic byp_q;
   logic sel_id;

   bsp_pin_sync u_sync
   (
      .clk_sys (clk_sys),
      .rst_n (rst_n),
      .pin_raw ({pin_drive_enable, test_port_reset_n, test_serial_in,
                 test_state_select, test_shift_clock}),
      .pins (pins.src)
   );

   // Port reset acts straight from the pin, no test clock needed;
   // release waits for the synchronised level so it lands clear of an edge
   assign port_rst_n = rst_n & test_port_reset_n
                       & pins.lvl[PIN_TRST];
   assign tck_rise = pins.rise[PIN_TCK];
   assign tck_fall = pins.fall[PIN_TCK];
   assign tms = pins.lvl[PIN_TMS];
   assign tdi = pins.lvl[PIN_TDI];
   assign sel_id = (ir_q == INS_IDCODE);

   // Standard state walk steered by the select line
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         BSP_RESET: state_d = tms ? BSP_RESET : BSP_IDLE;
         BSP_IDLE: state_d = tms ? BSP_SEL_DR : BSP_IDLE;
         BSP_SEL_DR: state_d = tms ? BSP_SEL_IR : BSP_CAP_DR;
         BSP_CAP_DR: state_d = tms ? BSP_EX1_DR : BSP_SH_DR;
         BSP_SH_DR: state_d = tms ? BSP_EX1_DR : BSP_SH_DR;
         BSP_EX1_DR: state_d = tms ? BSP_UPD_DR : BSP_PAU_DR;
         BSP_PAU_DR: state_d = tms ? BSP_EX2_DR : BSP_PAU_DR;
         BSP_EX2_DR: state_d = tms ? BSP_UPD_DR : BSP_SH_DR;
         BSP_UPD_DR: state_d = tms ? BSP_SEL_DR : BSP_IDLE;
         BSP_SEL_IR: state_d = tms ? BSP_RESET : BSP_CAP_IR;
         BSP_CAP_IR: state_d = tms ? BSP_EX1_IR : BSP_SH_IR;
         BSP_SH_IR: state_d = tms ? BSP_EX1_IR : BSP_SH_IR;
         BSP_EX1_IR: state_d = tms ? BSP_UPD_IR : BSP_PAU_IR;
         BSP_PAU_IR: state_d = tms ? BSP_EX2_IR : BSP_PAU_IR;
         BSP_EX2_IR: state_d = tms ? BSP_UPD_IR : BSP_SH_IR;
         BSP_UPD_IR: state_d = tms ? BSP_SEL_DR : BSP_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge port_rst_n)
   begin
      if (!port_rst_n)
         state_q <= BSP_RESET;
      else if (tck_rise)
         state_q <= state_d;
   end

   // Instruction path; reset leaves the identification read selected
   always_ff @(posedge clk_sys or negedge port_rst_n)
   begin
      if (!port_rst_n)
      begin
         ir_sh_q <= IR_CAPTURE;
         ir_q <= INS_IDCODE;
      end
      else if (tck_rise)
      begin
         unique case (state_q)
            BSP_RESET: ir_q <= INS_IDCODE;
            BSP_CAP_IR: ir_sh_q <= IR_CAPTURE;
            BSP_SH_IR: ir_sh_q <= {tdi, ir_sh_q[IR_W-1:1]};
            BSP_UPD_IR: ir_q <= ir_sh_q;
            default: ir_q <= ir_q;
         endcase
      end
   end

   // Data path: identification word register
   always_ff @(posedge clk_sys or negedge port_rst_n)
   begin
      if (!port_rst_n)
         dr_sh_q <= '0;
      else if (tck_rise && sel_id)
      begin
         if (state_q == BSP_CAP_DR)
            dr_sh_q <= ID_CODE;
         else if (state_q == BSP_SH_DR)
            dr_sh_q <= {tdi, dr_sh_q[ID_W-1:1]};
      end
   end

   // Any other code is one-bit bypass, capturing zero
   always_ff @(posedge clk_sys or negedge port_rst_n)
   begin
      if (!port_rst_n)
         byp_q <= 1'b0;
      else if (tck_rise && !sel_id)
      begin
         if (state_q == BSP_CAP_DR)
            byp_q <= 1'b0;
         else if (state_q == BSP_SH_DR)
            byp_q <= tdi;
      end
   end

   // Serial source for the current shift state
   always_comb
   begin
      shifting = 1'b0;
      shift_bit = 1'b0;
      unique case (state_q)
         BSP_SH_IR:
         begin
            shifting = 1'b1;
            shift_bit = ir_sh_q[0];
         end
         BSP_SH_DR:
         begin
            shifting = 1'b1;
            shift_bit = sel_id ? dr_sh_q[0] : byp_q;
         end
         default:
         begin
            shifting = 1'b0;
            shift_bit = 1'b0;
         end
      endcase
   end

   // Output moves half a test clock after capture, so it is stable
   // when the tester samples it as it next drops the test clock
   always_ff @(posedge clk_sys or negedge port_rst_n)
   begin
      if (!port_rst_n)
      begin
         tdo_q <= 1'b0;
         tdo_oe_q <= 1'b0;
      end
      else if (tck_fall)
      begin
         tdo_q <= shifting ? shift_bit : 1'b0;
         tdo_oe_q <= shifting;
      end
   end

   // Test mode starts on the reset release and ends while it is low
   always_ff @(posedge clk_sys or negedge port_rst_n)
   begin
      if (!port_rst_n)
         test_mode_q <= 1'b0;
      else if (pins.rise[PIN_TRST])
         test_mode_q <= 1'b1;
   end

   // Float uses synchronised levels; a few cycles of lag is harmless
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         float_q <= 1'b0;
      else
         float_q <= ~pins.lvl[PIN_IOEN] & ~pins.lvl[PIN_TRST];
   end

   assign test_serial_out = tdo_q;
   assign test_serial_out_oe = tdo_oe_q;
   assign test_mode_active = test_mode_q;
   assign pins_float = float_q;
   assign active_instruction = ir_q;
endmodule
`default_nettype wire

// ---- bench/bsp_tap_monitor.sv ----
// Port checker for the boundary-scan test port
`timescale 1ns/1ps
`default_nettype none
module bsp_tap_monitor
(
   // Clock and resets
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic test_port_reset_n,
   // Pins in
   input wire logic test_shift_clock,
   input wire logic pin_drive_enable,
   // Outputs
   input wire logic test_serial_out,
   input wire logic test_serial_out_oe,
   input wire logic test_mode_active,
   input wire logic pins_float,
   input wire logic [bsp_pkg::IR_W-1:0] active_instruction
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   property p_ctl;
      !test_port_reset_n |-> !test_serial_out_oe && active_instruction == 4'h1;
   endproperty
   a_ctl: assert property (p_ctl) else $error("port not reset");
   property p_leave; !test_port_reset_n |-> !test_mode_active; endproperty
   a_leave: assert property (p_leave) else $error("test mode held");
   property p_id; $rose(test_port_reset_n) |-> ##[1:6] test_mode_active;
   endproperty
   a_id: assert property (p_id) else $error("no id mode");
   property p_float;
      (!pin_drive_enable && !test_port_reset_n) [*4] |-> pins_float;
   endproperty
   a_float: assert property (p_float) else $error("pins not floated");
   property p_norm; pin_drive_enable [*4] |-> !pins_float; endproperty
   a_norm: assert property (p_norm) else $error("pins floated");
   // Sync lag puts the output change two edges after a low test clock
   property p_shift; $changed(test_serial_out) && test_port_reset_n
      |-> !$past(test_shift_clock, 2); endproperty
   a_shift: assert property (p_shift) else $error("out off edge");
   property p_quiet; !test_serial_out_oe |-> !test_serial_out; endproperty
   a_quiet: assert property (p_quiet) else $error("out when idle");
   property p_oe; test_serial_out_oe |-> test_mode_active; endproperty
   a_oe: assert property (p_oe) else $error("drive outside test");
endmodule
bind bsp_tap bsp_tap_monitor u_mon (.clk_sys(clk_sys), .rst_n(rst_n),
   .test_port_reset_n(test_port_reset_n), .test_shift_clock(test_shift_clock),
   .pin_drive_enable(pin_drive_enable), .test_serial_out(test_serial_out),
   .test_serial_out_oe(test_serial_out_oe), .pins_float(pins_float),
   .test_mode_active(test_mode_active),
   .active_instruction(active_instruction));
`default_nettype wire

// ---- bench/bsp_tester.sv ----
// Tester model driving the test port pins
`timescale 1ns/1ps
`default_nettype none
module bsp_tester
(
   // Bench clock
   input wire logic clk_sys,
   // Test port pins
   output var logic shift_clk,
   output var logic state_sel,
   output var logic ser_in,
   output var logic port_rst_n,
   input wire logic ser_out
);
   initial
   begin
      shift_clk = 1'b0;
      state_sel = 1'b1;
      ser_in = 1'b1;
      port_rst_n = 1'b0;
   end
   task automatic set_trst(input logic v);
      @(negedge clk_sys);
      port_rst_n = v;
   endtask
   // 100 ns low, 100 ns high; clock stops low, pulled-up lines go high
   task automatic tick(input logic ms, input logic di, output logic dv);
      @(negedge clk_sys);
      state_sel = ms;
      ser_in = di;
      repeat (3) @(negedge clk_sys);
      shift_clk = 1'b1;
      repeat (4) @(negedge clk_sys);
      dv = ser_out;
      shift_clk = 1'b0;
      state_sel = 1'b1;
      ser_in = 1'b1;
   endtask
endmodule
`default_nettype wire

// ---- bench/boundary_scan_test_port_tb.sv ----
// Testbench for the boundary-scan test port
`timescale 1ns/1ps
`default_nettype none
module boundary_scan_test_port_tb;
   import bsp_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic io_en = 1'b0;
   wire logic tck, tms, tdi, trst_n, so, so_oe, mode, flt, tdo_pin;
   wire logic [IR_W-1:0] ins;
   logic [63:0] got;
   int error_cnt = 0;
   int compares = 0;
   int cyc = 0;
   assign tdo_pin = so_oe ? so : 1'bz;
   always #12.5 clk_sys = ~clk_sys;
   bsp_tester u_tst (.clk_sys(clk_sys), .shift_clk(tck), .state_sel(tms),
      .ser_in(tdi), .port_rst_n(trst_n), .ser_out(tdo_pin));
   bsp_tap u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .test_shift_clock(tck),
      .test_state_select(tms), .test_serial_in(tdi),
      .test_port_reset_n(trst_n), .pin_drive_enable(io_en),
      .test_serial_out(so), .test_serial_out_oe(so_oe),
      .test_mode_active(mode), .pins_float(flt), .active_instruction(ins));
   task automatic summarize;
      $display("Checks %0d, errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      compares++;
      if (g !== e)
      begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // Select and data bits go out LSB first, one per test clock
   task automatic scan(input logic [63:0] ms, input logic [63:0] di, int n);
      for (int i = 0; i < n; i++)
         u_tst.tick(ms[i], di[i], got[i]);
   endtask
   task automatic t_float;
      repeat (6) @(negedge clk_sys);
      chk(flt, 1'b1);
      chk(mode, 1'b0);
      io_en = 1'b1;
      repeat (6) @(negedge clk_sys);
      chk(flt, 1'b0);
   endtask
   task automatic t_idcode;
      u_tst.set_trst(1'b1);
      repeat (6) @(negedge clk_sys);
      chk(mode, 1'b1);
      chk(ins, INS_IDCODE);
      scan(64'h18_0000_0002, 64'h0, 38);
      chk(got[35:4], ID_VALUE);
      chk(got[3], 1'bz);
      chk(got[36], 1'bz);
   endtask
   task automatic t_bypass;
      scan(64'h183, 64'hf0, 10);
      chk(got[7:4], IR_CAPTURE);
      chk(ins, INS_BYPASS);
      scan(64'hc01, 64'h590, 13);
      chk(got[10:3], 8'h64);
   endtask
   task automatic t_tms_reset;
      scan(64'h1f, 64'h0, 6);
      chk(ins, INS_IDCODE);
   endtask
   // Port reset dropped in mid-shift must act before any clock edge
   task automatic t_abort;
      scan(64'h1, 64'h0, 6);
      repeat (6) @(negedge clk_sys);
      chk(so_oe, 1'b1);
      u_tst.set_trst(1'b0);
      #1;
      chk(so_oe, 1'b0);
      chk(mode, 1'b0);
      @(negedge clk_sys);
      io_en = 1'b0;
      repeat (6) @(negedge clk_sys);
      chk(flt, 1'b1);
   endtask
   initial
   begin
      repeat (16) @(negedge clk_sys);
      rst_n = 1'b1;
      t_float();
      t_idcode();
      t_bypass();
      t_tms_reset();
      t_abort();
      summarize();
   end
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         error_cnt++;
         summarize();
      end
   end
endmodule
`default_nettype wire
